// File: logic/ring_port_redundancy_select.sv
// ring port redundancy selector: input/output port choice and clock source
`timescale 1ns/1ps
module ring_port_redundancy_select
    import ring_redundancy_pkg::*;
(
    input wire logic clock_in,
    input wire logic sys_rst_in,
    input wire logic port_a_clock_in,
    input wire logic port_b_clock_in,
    input wire rx_frame_s port_a_frame_in,
    input wire rx_frame_s port_b_frame_in,
    output logic node_clock_out,
    output logic clock_select_out,
    output logic [7:0] ctrl_c_out,
    output logic [7:0] status_c_out,
    output logic active_input_port_flag_out,
    output logic port_a_accept_out,
    output logic port_b_accept_out,
    output logic port_a_transmit_out,
    output logic port_b_transmit_out,
    output logic forward_drop_out
);
    logic [SYNC_STAGES-1:0] rst_a_sync;
    logic [SYNC_STAGES-1:0] rst_b_sync;
    wire rst_a = rst_a_sync[SYNC_STAGES-1];
    wire rst_b = rst_b_sync[SYNC_STAGES-1];

    always_ff @(posedge port_a_clock_in) begin
        rst_a_sync <= {rst_a_sync[SYNC_STAGES-2:0], sys_rst_in};
    end

    always_ff @(posedge port_b_clock_in) begin
        rst_b_sync <= {rst_b_sync[SYNC_STAGES-2:0], sys_rst_in};
    end

    // packet capture in each port domain: held word plus toggle event
    rx_frame_s held_a;
    rx_frame_s held_b;
    logic toggle_a;
    logic toggle_b;

    always_ff @(posedge port_a_clock_in) begin
        if (rst_a) begin
            held_a <= '0;
            toggle_a <= 1'b0;
        end else if (port_a_frame_in.done) begin
            held_a <= port_a_frame_in;
            toggle_a <= ~toggle_a;
        end
    end

    always_ff @(posedge port_b_clock_in) begin
        if (rst_b) begin
            held_b <= '0;
            toggle_b <= 1'b0;
        end else if (port_b_frame_in.done) begin
            held_b <= port_b_frame_in;
            toggle_b <= ~toggle_b;
        end
    end

    // toggles into the system clock domain
    logic [SYNC_STAGES:0] tog_a_sync;
    logic [SYNC_STAGES:0] tog_b_sync;

    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            tog_a_sync <= '0;
            tog_b_sync <= '0;
        end else begin
            tog_a_sync <= {tog_a_sync[SYNC_STAGES-1:0], toggle_a};
            tog_b_sync <= {tog_b_sync[SYNC_STAGES-1:0], toggle_b};
        end
    end

    wire event_a = tog_a_sync[SYNC_STAGES] ^ tog_a_sync[SYNC_STAGES-1];
    wire event_b = tog_b_sync[SYNC_STAGES] ^ tog_b_sync[SYNC_STAGES-1];

    // the held word is stable while its event crosses; B wins a same-cycle tie
    wire from_b = event_b;
    wire frame_event = event_a | event_b;
    wire rx_frame_s frame = from_b ? held_b : held_a;

    logic [7:0] ctrl_c;
    logic [7:0] status_c;
    switch_state_e state;
    switch_state_e next_state;

    wire active_port = status_c[ACTIVE_PORT_BIT];
    wire on_active = (from_b == active_port);

    wire good_write = frame_event & frame.good & (frame.code == CMD_WRITE_CTRL_C);

    wire want_b = from_b & (frame.data == SWITCH_TO_B_VALUE);
    wire want_a = ~from_b & ~frame.data[INPUT_SEL_BIT];

    wire switch_cmd = good_write & ~on_active & (from_b ? want_b : want_a);
    wire active_write = good_write & on_active;
    wire accept_write = (active_write | switch_cmd) & (state == STEADY);

    wire [7:0] next_ctrl_c = frame.data;
    wire next_input_port = switch_cmd ? from_b : active_port;

    // clock switch enables seen from the system domain
    logic en_a_raw;
    logic en_b_raw;
    logic [SYNC_STAGES-1:0] en_a_sync;
    logic [SYNC_STAGES-1:0] en_b_sync;
    wire en_a_seen = en_a_sync[SYNC_STAGES-1];
    wire en_b_seen = en_b_sync[SYNC_STAGES-1];
    wire clk_switch_done = active_port ? (en_b_seen & ~en_a_seen) : (en_a_seen & ~en_b_seen);

    always_comb begin
        next_state = state;
        case (state)
            STEADY: begin
                if (accept_write && switch_cmd) begin
                    next_state = SWITCHING;
                end
            end
            SWITCHING: begin
                if (clk_switch_done) begin
                    next_state = STEADY;
                end
            end
            default: begin
                next_state = STEADY;
            end
        endcase
    end

    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            en_a_sync <= '1;
            en_b_sync <= '0;
        end else begin
            en_a_sync <= {en_a_sync[SYNC_STAGES-2:0], en_a_raw};
            en_b_sync <= {en_b_sync[SYNC_STAGES-2:0], en_b_raw};
        end
    end

    logic drop;

    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            ctrl_c <= CTRL_C_RESET;
            status_c <= STATUS_C_RESET;
            state <= STEADY;
            drop <= 1'b0;
        end else begin
            state <= next_state;
            if (accept_write) begin
                ctrl_c <= next_ctrl_c;
            end
            status_c[ACTIVE_PORT_BIT] <= accept_write ? next_input_port : active_port;
            drop <= accept_write & switch_cmd;
        end
    end

    glitchless_clock_switch u_clock_switch (
        .port_a_clock_in(port_a_clock_in),
        .port_b_clock_in(port_b_clock_in),
        .rst_a_in(rst_a),
        .rst_b_in(rst_b),
        .select_b_in(active_port),
        .clock_out(node_clock_out),
        .enable_a_out(en_a_raw),
        .enable_b_out(en_b_raw)
    );

    wire out_sel_b = ctrl_c[OUTPUT_SEL_BIT];
    logic [SYNC_STAGES-1:0] out_b_in_a;
    logic [SYNC_STAGES-1:0] out_b_in_b;
    logic tx_a;
    logic tx_b;

    always_ff @(posedge port_a_clock_in) begin
        if (rst_a) begin
            out_b_in_a <= '0;
            tx_a <= 1'b1;
        end else begin
            out_b_in_a <= {out_b_in_a[SYNC_STAGES-2:0], out_sel_b};
            tx_a <= ~out_b_in_a[SYNC_STAGES-1];
        end
    end

    always_ff @(posedge port_b_clock_in) begin
        if (rst_b) begin
            out_b_in_b <= '0;
            tx_b <= 1'b0;
        end else begin
            out_b_in_b <= {out_b_in_b[SYNC_STAGES-2:0], out_sel_b};
            tx_b <= out_b_in_b[SYNC_STAGES-1];
        end
    end

    logic clk_sel;

    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            clk_sel <= 1'b0;
        end else begin
            clk_sel <= active_port;
        end
    end

    assign clock_select_out = clk_sel;
    assign ctrl_c_out = ctrl_c;
    assign status_c_out = status_c;
    assign active_input_port_flag_out = active_port;
    assign port_a_accept_out = (active_port == PORT_A);
    assign port_b_accept_out = (active_port == PORT_B);
    assign port_a_transmit_out = tx_a;
    assign port_b_transmit_out = tx_b;
    assign forward_drop_out = drop;
endmodule

// File: logic/ring_redundancy_pkg.sv
// constants and carrier types for the ring port redundancy selector
package ring_redundancy_pkg;

    localparam logic [7:0] CMD_WRITE_CTRL_C = 8'h02;
    localparam logic [7:0] SWITCH_TO_B_VALUE = 8'h01;
    localparam int INPUT_SEL_BIT = 0;
    localparam int OUTPUT_SEL_BIT = 1;
    localparam int ACTIVE_PORT_BIT = 0;
    localparam logic [7:0] CTRL_C_RESET = 8'h00;
    localparam logic [7:0] STATUS_C_RESET = 8'h00;
    localparam logic PORT_A = 1'b0;
    localparam logic PORT_B = 1'b1;
    localparam int SYNC_STAGES = 2;

    // one received packet, as reported by the command decoder at packet end
    typedef struct packed {
        logic done;
        logic good;
        logic [7:0] code;
        logic [7:0] data;
    } rx_frame_s;

    typedef enum logic [1:0] {
        STEADY = 2'b01,
        SWITCHING = 2'b10
    } switch_state_e;

endpackage

// File: logic/glitchless_clock_switch.sv
// glitch-free switch between the two ring port clocks
`timescale 1ns/1ps
module glitchless_clock_switch
    import ring_redundancy_pkg::*;
(
    input wire logic port_a_clock_in,
    input wire logic port_b_clock_in,
    input wire logic rst_a_in,
    input wire logic rst_b_in,
    input wire logic select_b_in,
    output logic clock_out,
    output logic enable_a_out,
    output logic enable_b_out
);
    logic req_a_meta;
    logic req_a;
    logic req_b_meta;
    logic req_b;
    logic en_a;
    logic en_b;

    always_ff @(posedge port_a_clock_in) begin
        if (rst_a_in) begin
            req_a_meta <= 1'b1;
            req_a <= 1'b1;
        end else begin
            req_a_meta <= ~select_b_in & ~en_b;
            req_a <= req_a_meta;
        end
    end

    // enables change on the falling edge, while the gated clock is low
    always_ff @(negedge port_a_clock_in) begin
        if (rst_a_in) begin
            en_a <= 1'b1;
        end else begin
            en_a <= req_a;
        end
    end

    always_ff @(posedge port_b_clock_in) begin
        if (rst_b_in) begin
            req_b_meta <= 1'b0;
            req_b <= 1'b0;
        end else begin
            req_b_meta <= select_b_in & ~en_a;
            req_b <= req_b_meta;
        end
    end

    always_ff @(negedge port_b_clock_in) begin
        if (rst_b_in) begin
            en_b <= 1'b0;
        end else begin
            en_b <= req_b;
        end
    end

    assign clock_out = (port_a_clock_in & en_a) | (port_b_clock_in & en_b);
    assign enable_a_out = en_a;
    assign enable_b_out = en_b;
endmodule

// File: dv/ring_redundancy_props.sv
// port checks for the ring redundancy selector
`timescale 1ns/1ps
module ring_redundancy_props (
    input wire logic clock_in,
    input wire logic sys_rst_in,
    input wire logic [7:0] ctrl_c_out,
    input wire logic [7:0] status_c_out,
    input wire logic clock_select_out,
    input wire logic active_input_port_flag_out,
    input wire logic port_a_accept_out,
    input wire logic port_b_accept_out,
    input wire logic forward_drop_out
);
    default clocking @(posedge clock_in);
    endclocking
    default disable iff (sys_rst_in);
    chk_reset_clear: assert property ($past(sys_rst_in) |->
        ctrl_c_out == 8'h00 && status_c_out == 8'h00 && !clock_select_out)
        else $error("not reset");
    chk_flag_mirror: assert property (active_input_port_flag_out == status_c_out[0])
        else $error("flag");
    chk_spare_zero: assert property (status_c_out[7:1] == 7'h00)
        else $error("spare bits");
    chk_select_lag: assert property (clock_select_out == $past(status_c_out[0]))
        else $error("select");
    chk_accept_pair: assert property (port_b_accept_out == status_c_out[0]
        && port_a_accept_out != port_b_accept_out) else $error("accept");
    chk_drop_switch: assert property (forward_drop_out == $changed(status_c_out[0]))
        else $error("drop");
    chk_drop_single: assert property (forward_drop_out |=> !forward_drop_out)
        else $error("drop width");
    chk_switch_value: assert property ($changed(status_c_out[0]) |->
        ctrl_c_out[0] == status_c_out[0]) else $error("switch value");
endmodule
bind ring_port_redundancy_select ring_redundancy_props i_props (
    .clock_in(clock_in), .sys_rst_in(sys_rst_in), .ctrl_c_out(ctrl_c_out),
    .status_c_out(status_c_out), .clock_select_out(clock_select_out),
    .active_input_port_flag_out(active_input_port_flag_out),
    .port_a_accept_out(port_a_accept_out), .port_b_accept_out(port_b_accept_out),
    .forward_drop_out(forward_drop_out));

// File: dv/ring_neighbour_model.sv
// far-side model: ring neighbours feeding both ports
`timescale 1ns/1ps
module ring_neighbour_model
    import ring_redundancy_pkg::*;
(
    output logic port_a_clock_out,
    output logic port_b_clock_out,
    output rx_frame_s port_a_frame_out,
    output rx_frame_s port_b_frame_out
);
    initial begin
        port_a_clock_out = 1'b0;
        port_a_frame_out = '0;
        port_b_frame_out = '0;
        forever #32 port_a_clock_out = ~port_a_clock_out;
    end
    initial begin
        port_b_clock_out = 1'b0;
        #17;
        forever #32 port_b_clock_out = ~port_b_clock_out;
    end
    // one packet end; fields flip once it is over
    task automatic send(input logic b, input logic g, input logic [7:0] c, input logic [7:0] d);
        rx_frame_s f;
        f = {1'b1, g, c, d};
        if (b) begin
            @(posedge port_b_clock_out) port_b_frame_out <= f;
            @(posedge port_b_clock_out) port_b_frame_out <= {1'b0, ~f[16:0]};
        end else begin
            @(posedge port_a_clock_out) port_a_frame_out <= f;
            @(posedge port_a_clock_out) port_a_frame_out <= {1'b0, ~f[16:0]};
        end
    endtask
endmodule

// File: dv/ring_port_redundancy_select_tb.sv
// bench for the ring redundancy selector
`timescale 1ns/1ps
module ring_port_redundancy_select_tb;
    import ring_redundancy_pkg::*;
    logic clock_in, sys_rst_in, ca, cb, nclk, csel, flag, aa, ab, ta, tb, drop;
    logic [7:0] ctrl, st;
    rx_frame_s fa, fb;
    int error_cnt = 0;
    int n_tests = 0;
    ring_neighbour_model i_nbr (.port_a_clock_out(ca), .port_b_clock_out(cb),
        .port_a_frame_out(fa), .port_b_frame_out(fb));
    ring_port_redundancy_select i_dut (.clock_in(clock_in), .sys_rst_in(sys_rst_in),
        .port_a_clock_in(ca), .port_b_clock_in(cb), .port_a_frame_in(fa),
        .port_b_frame_in(fb), .node_clock_out(nclk), .clock_select_out(csel),
        .ctrl_c_out(ctrl), .status_c_out(st), .active_input_port_flag_out(flag),
        .port_a_accept_out(aa), .port_b_accept_out(ab), .port_a_transmit_out(ta),
        .port_b_transmit_out(tb), .forward_drop_out(drop));
    initial begin
        clock_in = 1'b0;
        forever #50 clock_in = ~clock_in;
    end
    task automatic finish_test();
        $display("checks %0d errors %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value %0t %s: %h not %h", $time, m, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clock_in);
        #1;
    endtask
    // bounded wait for a switch pulse or a new ctrl value
    task automatic await(input logic sw, input logic [7:0] v);
        int i;
        for (i = 0; i < 40 && !(sw ? drop === 1'b1 : ctrl === v); i++) cyc(1);
        chk({7'h00, i < 40}, 8'h01, "wait");
        if (i == 40) finish_test();
    endtask
    task automatic do_reset();
        @(posedge clock_in) sys_rst_in <= 1'b1;
        cyc(3);
        @(posedge clock_in) sys_rst_in <= 1'b0;
        cyc(4);
    endtask
    task automatic follow(input logic on_b);
        int k;
        cyc(10);
        for (k = 0; k < 6; k++) begin
            if (on_b) @(posedge cb);
            else @(posedge ca);
            #5 chk({7'h00, nclk}, 8'h01, "clk hi");
            #32 chk({7'h00, nclk}, 8'h00, "clk lo");
        end
    endtask
    task automatic t_reset();
        chk(ctrl | st, 8'h00, "regs");
        chk({4'h0, csel, ab, aa, ta}, 8'h03, "sel");
        chk({7'h00, tb}, 8'h00, "tx b");
        $display("reset done");
    endtask
    task automatic t_refuse();
        logic [16:0] bad [3] = '{17'h0_0201, 17'h1_0301, 17'h1_0203};
        foreach (bad[k]) begin
            i_nbr.send(1'b1, bad[k][16], bad[k][15:8], bad[k][7:0]);
            cyc(10);
            chk(st | ctrl, 8'h00, "refused");
        end
        $display("refuse done");
    endtask
    task automatic t_switch_b();
        i_nbr.send(1'b1, 1'b1, CMD_WRITE_CTRL_C, SWITCH_TO_B_VALUE);
        await(1'b1, 8'h00);
        chk(st, 8'h01, "status");
        cyc(1);
        chk({6'h00, csel, ab}, 8'h03, "sel");
        follow(1'b1);
        i_nbr.send(1'b0, 1'b1, CMD_WRITE_CTRL_C, 8'h01);
        cyc(10);
        chk(st | ctrl, 8'h01, "ignore a");
        $display("switch done");
    endtask
    task automatic t_output_b();
        i_nbr.send(1'b1, 1'b1, CMD_WRITE_CTRL_C, 8'h03);
        await(1'b0, 8'h03);
        cyc(8);
        chk({5'h00, st[0], ta, tb}, 8'h05, "out b");
        $display("output done");
    endtask
    task automatic t_back_a();
        i_nbr.send(1'b0, 1'b1, CMD_WRITE_CTRL_C, 8'h02);
        await(1'b1, 8'h00);
        chk(ctrl | st, 8'h02, "back a");
        cyc(8);
        chk({5'h00, csel, ta, tb}, 8'h01, "out");
        follow(1'b0);
        i_nbr.send(1'b0, 1'b1, CMD_WRITE_CTRL_C, 8'h00);
        await(1'b0, 8'h00);
        cyc(8);
        chk({6'h00, ta, tb}, 8'h02, "out a");
        $display("back done");
    endtask
    initial begin
        sys_rst_in = 1'b1;
        do_reset();
        t_reset();
        t_refuse();
        t_switch_b();
        t_output_b();
        do_reset();
        t_reset();
        t_switch_b();
        t_back_a();
        finish_test();
    end
endmodule
